// [vgc_global_csr.v]
// Bus error cause register and global register set of the VME interface.
`timescale 1ns/1ps
`include "vgc_consts.vh"

// Operation
// - Reading cause register returns it, then clears.
// - Only latest bus error cause is kept.
// - Bit0 local timeout, bit1 VME access timeout.
// - Bit2 on BERR of own unposted cycle.
// - Base field matches A4-A7, A8-A15 zero.
// - Reset base all ones; then no response.
// - Unmapped set disables monitors and attention.
// - Eight byte registers, local and odd VME.
// - Low nibble of register 0 is chip id.
// - Monitor 0 clears at F0/F1, level 2.
// - Monitor 1 clears at F2/F3, level 4.
// - Monitors 2,3 clear at F4-F7, no interrupt.
// - Monitors 0,1 re-set on acknowledge or write.
// - Matching monitor drives DTACK to end cycle.
// - Low attention set by VME, level 1.
// - High attention set by VME, level 5.
// - Board failure bit follows failure line.
// - Inhibit bit stops SYSFAIL drive only.
// - Strap bit reads jumper pins 1-2 fitted.
// - Reset-hold keeps board reset until cleared.
// - Board id local RW, VME read-only.
module vgc_global_csr #(
	parameter [3:0] CHIP_IDENT = 4'h5 // Arbitrary value.
) (
	input  wire        clock,
	input  wire        rst_n,
	input  wire        loc_sel,
	input  wire        loc_wr,
	input  wire [31:0] loc_addr,
	input  wire [7:0]  loc_wdata,
	output reg  [7:0]  loc_rdata_ff,
	output reg         loc_ack_ff,
	input  wire        vme_as,
	input  wire        vme_super_short,
	input  wire [15:1] vme_addr,
	input  wire        vme_ds0,
	input  wire        vme_ds1,
	input  wire        vme_write,
	input  wire [7:0]  vme_wdata,
	output reg  [7:0]  vme_rdata_ff,
	output reg         vme_dtack_ff,
	input  wire        local_timer_expired,
	input  wire        access_timer_expired,
	input  wire        own_unposted_berr,
	input  wire        mon0_int_en,
	input  wire        mon1_int_en,
	input  wire        low_attn_int_en,
	input  wire        high_attn_int_en,
	input  wire        mon0_int_ack,
	input  wire        mon1_int_ack,
	input  wire        board_fail_line,
	input  wire        board_fail_assert,
	input  wire        controller_enable_jumper,
	output reg         mon0_irq_ff,
	output reg         mon1_irq_ff,
	output reg         low_attn_irq_ff,
	output reg         high_attn_irq_ff,
	output reg         sysfail_drive_ff,
	output reg         board_reset_hold_ff
);

	reg  [2:0] cause_ff;
	reg  [3:0] base_ff;
	reg  [3:0] mon_ff;
	reg        low_attn_ff;
	reg        high_attn_ff;
	reg        inhibit_sysfail_ff;
	reg        reset_hold_ff;
	reg  [7:0] board_ident_ff;
	reg  [7:0] scratch_ff [0:4];
	reg        vme_busy_ff;

	reg  [2:0] nxt_cause;
	reg  [3:0] nxt_mon;
	reg  [7:0] loc_rd;
	reg  [7:0] vme_rd;
	integer    i;

	// Register number 0..7 of the global set from a local address.
	function [3:0] loc_gidx;
		input [31:0] a;
		reg   [31:0] d;
		begin
			d = a - `VGC_OFF_GREG0;
			if (a >= `VGC_OFF_GREG0 && a <= `VGC_OFF_SCRATCH4 && a[0])
				loc_gidx = {1'b0, d[3:1]};
			else
				loc_gidx = 4'h8;
		end
	endfunction

	wire       mapped   = (base_ff != `VGC_BASE_NONE);
	wire       start    = vme_as & vme_super_short & ~vme_busy_ff &
	                      (vme_ds0 | vme_ds1);
	wire       single   = vme_ds0 ^ vme_ds1;
	wire       dbl      = vme_ds0 & vme_ds1;
	// Odd byte lane alone for single access, even address for double.
	wire       odd_addr = single & vme_ds0;
	wire       gset_hit = start & mapped & odd_addr &
	                      (vme_addr[15:8] == `VGC_GSET_ADDR_HI) &
	                      (vme_addr[7:4] == base_ff);
	wire [2:0] vreg     = vme_addr[3:1];
	// Monitors sit in the lower half of the 00f0 line, 00f0 to 00f7.
	wire       mon_blk  = (vme_addr[15:4] == `VGC_MON_ADDR_HI) &
	                      ~vme_addr[3];
	wire       mon_hit  = start & mapped & mon_blk &
	                      (dbl | (single & vme_ds0));
	wire [1:0] mon_sel  = vme_addr[2:1];
	wire       vme_wr_g = gset_hit & vme_write;
	wire [3:0] lidx     = loc_gidx(loc_addr);
	wire       loc_wr_g = loc_sel & loc_wr & ~lidx[3];
	wire       loc_rd_c = loc_sel & ~loc_wr &
	                      (loc_addr == `VGC_OFF_BERR_CAUSE);

	// Cause register: newest event replaces older ones; a read clears,
	// but an event in the read cycle survives so it is never lost.
	always @* begin
		nxt_cause = cause_ff;
		if (loc_rd_c)
			nxt_cause = 3'h0;
		if (own_unposted_berr)
			nxt_cause = 3'h1 << `VGC_BIT_VME_ERR;
		else if (access_timer_expired)
			nxt_cause = 3'h1 << `VGC_BIT_ACCESS_TO;
		else if (local_timer_expired)
			nxt_cause = 3'h1 << `VGC_BIT_LOCAL_TO;
	end

	// Monitor flags are active low: cleared by a hit, set by writes.
	always @* begin
		nxt_mon = mon_ff;
		if (loc_wr_g && lidx[2:0] == 3'h0)
			nxt_mon = mon_ff | loc_wdata[7:4];
		if (vme_wr_g && vreg == 3'h0)
			nxt_mon = nxt_mon | vme_wdata[7:4];
		if (mon0_int_ack)
			nxt_mon[0] = 1'b1;
		if (mon1_int_ack)
			nxt_mon[1] = 1'b1;
		if (mon_hit)
			nxt_mon[mon_sel] = 1'b0;
	end

	// Read view of a global register; the board id is the same from
	// both sides, only writes differ.
	function [7:0] gread;
		input [2:0] idx;
		begin
			case (idx)
			3'h0: gread = {mon_ff, CHIP_IDENT};
			3'h1: gread = {reset_hold_ff, controller_enable_jumper,
			               inhibit_sysfail_ff, board_fail_line,
			               2'b00, high_attn_ff, low_attn_ff};
			3'h2: gread = board_ident_ff;
			3'h3: gread = scratch_ff[0];
			3'h4: gread = scratch_ff[1];
			3'h5: gread = scratch_ff[2];
			3'h6: gread = scratch_ff[3];
			3'h7: gread = scratch_ff[4];
			default: gread = 8'h00;
			endcase
		end
	endfunction

	always @* begin
		if (loc_rd_c)
			loc_rd = {5'h00, cause_ff};
		else if (loc_addr == `VGC_OFF_GSET_BASE)
			loc_rd = {4'h0, base_ff};
		else if (!lidx[3])
			loc_rd = gread(lidx[2:0]);
		else
			loc_rd = 8'h00;
		vme_rd = gread(vreg);
	end

	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			cause_ff            <= 3'h0;
			base_ff             <= `VGC_BASE_RESET;
			mon_ff              <= `VGC_MON_RESET;
			low_attn_ff         <= 1'b0;
			high_attn_ff        <= 1'b0;
			inhibit_sysfail_ff  <= 1'b0;
			reset_hold_ff       <= 1'b0;
			board_ident_ff      <= 8'h00;
			scratch_ff[0]       <= `VGC_SCRATCH0_RESET;
			for (i = 1; i < 5; i = i + 1)
				scratch_ff[i]   <= `VGC_SCRATCH_RESET;
			vme_busy_ff         <= 1'b0;
			loc_rdata_ff        <= 8'h00;
			loc_ack_ff          <= 1'b0;
			vme_rdata_ff        <= 8'h00;
			vme_dtack_ff        <= 1'b0;
			mon0_irq_ff         <= 1'b0;
			mon1_irq_ff         <= 1'b0;
			low_attn_irq_ff     <= 1'b0;
			high_attn_irq_ff    <= 1'b0;
			sysfail_drive_ff    <= 1'b0;
			board_reset_hold_ff <= 1'b0;
		end else begin
			cause_ff     <= nxt_cause;
			mon_ff       <= nxt_mon;
			loc_ack_ff   <= loc_sel;
			loc_rdata_ff <= loc_rd;
			// One decode per address strobe; DTACK holds until AS drops.
			if (!vme_as) begin
				vme_busy_ff  <= 1'b0;
				vme_dtack_ff <= 1'b0;
			end else if (start && (gset_hit || mon_hit)) begin
				vme_busy_ff  <= 1'b1;
				vme_dtack_ff <= 1'b1;
				vme_rdata_ff <= gset_hit ? vme_rd : 8'h00;
			end
			if (loc_sel && loc_wr && loc_addr == `VGC_OFF_GSET_BASE)
				base_ff <= loc_wdata[3:0];
			// Attention bits: VME side sets, local side clears; a set
			// in the same cycle as a clear wins.
			if (vme_wr_g && vreg == 3'h1) begin
				if (vme_wdata[`VGC_BIT_LOW_ATTN])
					low_attn_ff <= 1'b1;
				else if (loc_wr_g && lidx[2:0] == 3'h1 &&
				         loc_wdata[`VGC_BIT_LOW_ATTN])
					low_attn_ff <= 1'b0;
				if (vme_wdata[`VGC_BIT_HIGH_ATTN])
					high_attn_ff <= 1'b1;
				else if (loc_wr_g && lidx[2:0] == 3'h1 &&
				         loc_wdata[`VGC_BIT_HIGH_ATTN])
					high_attn_ff <= 1'b0;
				inhibit_sysfail_ff <= vme_wdata[`VGC_BIT_INHIBIT_SF];
				reset_hold_ff <= vme_wdata[`VGC_BIT_RESET_HOLD];
			end else if (loc_wr_g && lidx[2:0] == 3'h1) begin
				if (loc_wdata[`VGC_BIT_LOW_ATTN])
					low_attn_ff <= 1'b0;
				if (loc_wdata[`VGC_BIT_HIGH_ATTN])
					high_attn_ff <= 1'b0;
				inhibit_sysfail_ff <= loc_wdata[`VGC_BIT_INHIBIT_SF];
				// The board may set its own hold but never clear it.
				if (loc_wdata[`VGC_BIT_RESET_HOLD])
					reset_hold_ff <= 1'b1;
			end
			if (loc_wr_g && lidx[2:0] == 3'h2)
				board_ident_ff <= loc_wdata;
			for (i = 0; i < 5; i = i + 1) begin
				// Registers 0..2 wrap to 5..7 here and never match.
				if (vme_wr_g && (vreg - 3'h3) == i[2:0])
					scratch_ff[i] <= vme_wdata;
				else if (loc_wr_g && (lidx[2:0] - 3'h3) == i[2:0])
					scratch_ff[i] <= loc_wdata;
			end
			mon0_irq_ff      <= ~nxt_mon[0] & mon0_int_en & mapped;
			mon1_irq_ff      <= ~nxt_mon[1] & mon1_int_en & mapped;
			low_attn_irq_ff  <= low_attn_ff & low_attn_int_en &
			                    mapped;
			high_attn_irq_ff <= high_attn_ff & high_attn_int_en &
			                    mapped;
			sysfail_drive_ff <= board_fail_assert &
			                    ~inhibit_sysfail_ff;
			board_reset_hold_ff <= reset_hold_ff;
		end
	end

endmodule

// [vgc_consts.vh]
// Constants for the global control and status register block.
`ifndef VGC_CONSTS_VH
`define VGC_CONSTS_VH
`define VGC_OFF_BERR_CAUSE   32'hfffe2019
`define VGC_OFF_GSET_BASE    32'hfffe201b
`define VGC_OFF_GREG0        32'hfffe2021
`define VGC_OFF_GREG1        32'hfffe2023
`define VGC_OFF_BOARD_IDENT  32'hfffe2025
`define VGC_OFF_SCRATCH0     32'hfffe2027
`define VGC_OFF_SCRATCH1     32'hfffe2029
`define VGC_OFF_SCRATCH2     32'hfffe202b
`define VGC_OFF_SCRATCH3     32'hfffe202d
`define VGC_OFF_SCRATCH4     32'hfffe202f
`define VGC_BIT_LOCAL_TO     0
`define VGC_BIT_ACCESS_TO    1
`define VGC_BIT_VME_ERR      2
`define VGC_BIT_LOW_ATTN     0
`define VGC_BIT_HIGH_ATTN    1
`define VGC_BIT_BRD_FAIL     4
`define VGC_BIT_INHIBIT_SF   5
`define VGC_BIT_STRAP        6
`define VGC_BIT_RESET_HOLD   7
`define VGC_BASE_RESET       4'hf
`define VGC_BASE_NONE        4'hf
`define VGC_MON_RESET        4'hf
`define VGC_SCRATCH0_RESET   8'hff
`define VGC_SCRATCH_RESET    8'h00
`define VGC_MON_ADDR_HI      12'h00f
`define VGC_GSET_ADDR_HI     8'h00
`define VGC_RESET_HOLD_US    35
`define VGC_CLK_MHZ          100
`define VGC_RESET_HOLD_CYC   (`VGC_RESET_HOLD_US * `VGC_CLK_MHZ)
`endif

// [vgc_global_csr_assertions.sv]
// Port checker for the global register block.
`timescale 1ns/1ps
module vgc_csr_checker (
	input logic clock,
	input logic rst_n,
	input logic loc_sel,
	input logic loc_wr,
	input logic loc_ack_ff,
	input logic vme_as,
	input logic vme_super_short,
	input logic vme_ds0,
	input logic vme_write,
	input logic vme_dtack_ff,
	input logic board_fail_assert,
	input logic sysfail_drive_ff,
	input logic board_reset_hold_ff,
	input logic low_attn_int_en,
	input logic low_attn_irq_ff
);
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_n);
	a_ack_one_cycle: assert property (loc_ack_ff == $past(loc_sel))
		else $error("local ack timing");
	a_dtack_holds: assert property (vme_dtack_ff && vme_as |=>
		vme_dtack_ff) else $error("dtack dropped early");
	a_dtack_release: assert property (!vme_as |=> !vme_dtack_ff)
		else $error("dtack stuck");
	a_dtack_cause: assert property ($rose(vme_dtack_ff) |->
		$past(vme_as && vme_super_short && vme_ds0)) else $error("stray dtack");
	a_hold_set_write: assert property ($rose(board_reset_hold_ff) |->
		$past(loc_sel && loc_wr) || $past(loc_sel && loc_wr, 2) ||
		$past(vme_as && vme_write)) else $error("hold set without write");
	a_hold_clear_vme: assert property ($fell(board_reset_hold_ff) |->
		$past(vme_as && vme_write)) else $error("hold cleared wrongly");
	a_sysfail_cause: assert property (!board_fail_assert[*2] |->
		!sysfail_drive_ff) else $error("sysfail without failure");
	a_low_irq_mask: assert property (!low_attn_int_en[*2] |->
		!low_attn_irq_ff) else $error("masked irq raised");
	cover property ($rose(vme_dtack_ff));
	cover property ($rose(board_reset_hold_ff));
	cover property ($rose(low_attn_irq_ff));
endmodule
bind vgc_global_csr vgc_csr_checker i_chk (.*);

// [vgc_vme_master.sv]
// Behavioural VMEbus master standing for the other boards.
`timescale 1ns/1ps
module vgc_vme_master (
	input  logic        clock,
	output logic        vme_as = 1'h0,
	output logic        vme_super_short = 1'h0,
	output logic [15:1] vme_addr = 15'h0,
	output logic        vme_ds0 = 1'h0,
	output logic        vme_ds1 = 1'h0,
	output logic        vme_write = 1'h0,
	output logic [7:0]  vme_wdata = 8'h00,
	input  logic [7:0]  vme_rdata_ff,
	input  logic        vme_dtack_ff
);
	// Address and data lines are inverted on release so a stale value never reads as good.
	task automatic xfer(input logic [15:0] a, input logic [2:0] c,
		input logic [7:0] d, output logic ok, output logic [7:0] q);
		ok = 1'h0;
		q = 8'h00;
		@(posedge clock);
		#1;
		{vme_ds1, vme_ds0, vme_write} = c;
		{vme_addr, vme_wdata} = {a[15:1], d};
		{vme_as, vme_super_short} = 2'h3;
		for (int n = 0; n < 8 && !ok; n++) begin
			@(posedge clock);
			{ok, q} = {vme_dtack_ff, vme_rdata_ff};
		end
		#1;
		{vme_as, vme_super_short, vme_ds1, vme_ds0} = 4'h0;
		{vme_addr, vme_wdata} = ~{vme_addr, vme_wdata};
	endtask
endmodule

// [vgc_global_csr_bench.sv]
// Self-checking bench for the global register block.
`timescale 1ns/1ps
`include "vgc_consts.vh"
module vgc_global_csr_bench;
	localparam logic [3:0]  CID = 4'h9; // Arbitrary value.
	localparam logic [31:0] G0 = `VGC_OFF_GREG0;
	localparam logic [31:0] G1 = `VGC_OFF_GREG1;
	localparam logic [31:0] CS = `VGC_OFF_BERR_CAUSE;
	logic        clock = 1'h0, rst_n = 1'h0, loc_sel = 1'h0, loc_wr = 1'h0;
	logic [31:0] loc_addr = 32'h0;
	logic [7:0]  loc_wdata = 8'h00, loc_rdata_ff, vme_rdata_ff, vme_wdata;
	logic [15:1] vme_addr;
	logic        vme_as, vme_super_short, vme_ds0, vme_ds1, vme_write;
	logic        loc_ack_ff, vme_dtack_ff, mon0_irq_ff, mon1_irq_ff;
	logic        low_attn_irq_ff, high_attn_irq_ff, sysfail_drive_ff;
	logic        board_reset_hold_ff, ok, board_fail_line = 1'h0;
	logic        local_timer_expired = 1'h0, access_timer_expired = 1'h0;
	logic        own_unposted_berr = 1'h0, board_fail_assert = 1'h0;
	logic        mon0_int_ack = 1'h0, mon1_int_ack = 1'h0;
	logic        mon0_int_en = 1'h1, mon1_int_en = 1'h1;
	logic        low_attn_int_en = 1'h1, high_attn_int_en = 1'h1;
	logic        controller_enable_jumper = 1'h1;
	logic [3:0]  b = 4'hf;
	logic [7:0]  q, r;
	logic [8:0]  e, exp_q[$];
	int          mismatches = 0, samples_checked = 0, cycles = 0;
	vgc_global_csr #(.CHIP_IDENT(CID)) i_dut (.*);
	vgc_vme_master i_vme (.*);
	always #5 clock = ~clock;
	task automatic test_done();
		$display("checks %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic chk(input logic [7:0] s, input logic [7:0] x,
		input string n);
		samples_checked++;
		if (s !== x) begin
			mismatches++;
			$display("wrong value %s expected %h seen %h", n, x, s);
		end
	endtask
	// A local read leaves its expectation for the watcher below.
	always @(posedge clock) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			mismatches++;
			test_done();
		end
		if (loc_ack_ff === 1'h1) begin
			e = exp_q.pop_front();
			if (e[8])
				chk(loc_rdata_ff, e[7:0], "local data");
		end
	end
	task automatic loc(input logic [31:0] a, input logic w,
		input logic [7:0] d, input logic [8:0] x);
		@(posedge clock);
		#1;
		{loc_sel, loc_wr, loc_addr, loc_wdata} = {1'h1, w, a, d};
		exp_q.push_back(x);
		@(posedge clock);
		#1;
		loc_sel = 1'h0;
	endtask
	task automatic rd(input logic [31:0] a, input logic [7:0] x);
		loc(a, 1'h0, 8'h00, {1'h1, x});
	endtask
	task automatic wr(input logic [31:0] a, input logic [7:0] d);
		loc(a, 1'h1, d, 9'h0);
	endtask
	task automatic vm(input logic [7:0] a, input logic [2:0] c,
		input logic [7:0] d, input logic k, input logic [8:0] x);
		i_vme.xfer({8'h00, a}, c, d, ok, q);
		chk({7'h0, ok}, {7'h0, k}, "dtack");
		if (x[8])
			chk(q, x[7:0], "vme data");
	endtask
	task automatic ev(input logic [2:0] v);
		@(posedge clock);
		#1;
		{own_unposted_berr, access_timer_expired, local_timer_expired} = v;
		@(posedge clock);
		#1;
		{own_unposted_berr, access_timer_expired, local_timer_expired} = 0;
	endtask
	initial begin
		void'($urandom(32'hbb94b9d1));
		repeat (3) @(posedge clock);
		#1;
		rst_n = 1'h1;
		rd(CS, 8'h00);
		rd(`VGC_OFF_GSET_BASE, 8'h0f);
		rd(32'hfffe2031, 8'h00);
		for (int i = 0; i < 8; i++)
			rd(G0 + 32'(2 * i), i == 0 ? {4'hf, CID} : i == 1 ? 8'h40 :
				i == 3 ? 8'hff : 8'h00);
		vm(8'hf3, 3'h3, 8'h01, 1'h0, 9'h0);
		vm(8'hf1, 3'h2, 8'h00, 1'h0, 9'h0);
		rd(G0, {4'hf, CID});
		rd(G1, 8'h40);
		b = 4'($urandom % 15);
		wr(`VGC_OFF_GSET_BASE, {4'h0, b});
		vm({b, 4'h1}, 3'h2, 8'h00, 1'h1, {1'h1, 4'hf, CID});
		vm({b, 4'h1}, 3'h4, 8'h00, 1'h0, 9'h0);
		i_vme.xfer({8'h01, b, 4'h1}, 3'h2, 8'h00, ok, q);
		chk({7'h0, ok}, 8'h00, "high address");
		for (int k = 0; k < 8; k++) begin
			vm(8'hf0 + 8'(k), k[0] ? 3'h2 : 3'h6, 8'h00, 1'h1, 9'h0);
			rd(G0, {4'hf & ~(4'h1 << k / 2), CID});
			if (k < 4) begin
				chk({7'h0, k < 2 ? mon0_irq_ff : mon1_irq_ff}, 8'h1, "irq");
				{mon1_int_ack, mon0_int_ack} = k < 2 ? 2'h1 : 2'h2;
				@(posedge clock);
				#1;
				{mon1_int_ack, mon0_int_ack} = 2'h0;
			end else
				wr(G0, 8'hf0);
			rd(G0, {4'hf, CID});
		end
		low_attn_int_en = 1'h0;
		vm({b, 4'h3}, 3'h3, 8'h01, 1'h1, 9'h0);
		rd(G1, 8'h41);
		chk({7'h0, low_attn_irq_ff}, 8'h00, "masked irq");
		low_attn_int_en = 1'h1;
		vm({b, 4'h3}, 3'h3, 8'h02, 1'h1, 9'h0);
		rd(G1, 8'h43);
		chk({6'h0, high_attn_irq_ff, low_attn_irq_ff}, 8'h03, "irq");
		wr(G1, 8'h03);
		wr(G1, 8'h03);
		rd(G1, 8'h40);
		{board_fail_assert, board_fail_line} = 2'h3;
		rd(G1, 8'h50);
		chk({7'h0, sysfail_drive_ff}, 8'h01, "sysfail");
		vm({b, 4'h3}, 3'h3, 8'h20, 1'h1, 9'h0);
		rd(G1, 8'h70);
		chk({7'h0, sysfail_drive_ff}, 8'h00, "sysfail");
		vm({b, 4'h3}, 3'h3, 8'h80, 1'h1, 9'h0);
		wr(G1, 8'h00);
		repeat (`VGC_RESET_HOLD_CYC) @(posedge clock);
		chk({7'h0, board_reset_hold_ff}, 8'h01, "hold");
		vm({b, 4'h3}, 3'h3, 8'h00, 1'h1, 9'h0);
		chk({7'h0, board_reset_hold_ff}, 8'h00, "hold");
		r = 8'($urandom);
		wr(`VGC_OFF_BOARD_IDENT, r);
		i_vme.xfer({8'h00, b, 4'h5}, 3'h3, ~r, ok, q);
		vm({b, 4'h5}, 3'h2, 8'h00, 1'h1, {1'h1, r});
		for (int i = 0; i < 3; i++) begin
			ev(3'h1 << i);
			rd(CS, 8'h01 << i);
			rd(CS, 8'h00);
		end
		ev(3'h2);
		ev(3'h1);
		rd(CS, 8'h01);
		repeat (2) @(posedge clock);
		#1;
		rst_n = 1'h0;
		@(posedge clock);
		#1;
		rst_n = 1'h1;
		vm({b, 4'h1}, 3'h2, 8'h00, 1'h0, 9'h0);
		repeat (2) @(posedge clock);
		test_done();
	end
endmodule
